// [src/pim_consts.svh]
/*
 * Constants of the interrupt acceptance logic: status word fields,
 * reset values and vector/workspace layout.
 * Assumes byte addressing with 16-bit words on even addresses.
 */
`ifndef PIM_CONSTS_SVH
`define PIM_CONSTS_SVH

// Mask field of the status word
`define PIM_MASK_MSB      15
`define PIM_MASK_LSB      12
`define PIM_STATUS_RST    16'h0000
// Sixteen levels over a four-bit code
`define PIM_LEVELS        16
// Vector pair: workspace pointer at level*4, program counter two bytes on
`define PIM_VEC_PC_OFS    16'h0002
// Saved context in registers 13, 14 and 15 of the new workspace
`define PIM_WS_R13_OFS    16'h001a
`define PIM_WS_R14_OFS    16'h001c
`define PIM_WS_R15_OFS    16'h001e

`endif

// [src/pim_pkg.sv]
/*
 * Types of the interrupt acceptance logic.
 * Assumes pim_consts.svh for field positions.
 */
`include "pim_consts.svh"

package pim_pkg;

    typedef logic [3:0] pim_level_t;

    // Status word: mask in bits 15..12, other flags below
    typedef struct packed {
        pim_level_t  mask;
        logic [11:0] flags;
    } pim_status_t;

    // Word access to memory for vectors and context save
    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pim_mem_req_t;

    typedef enum logic [2:0] {
        PIM_IDLE   = 3'b000,
        PIM_VEC_WP = 3'b001,
        PIM_VEC_PC = 3'b011,
        PIM_SAV_WP = 3'b010,
        PIM_SAV_PC = 3'b110,
        PIM_SAV_ST = 3'b111,
        PIM_FIRST  = 3'b101
    } pim_state_t;

endpackage : pim_pkg

// [src/pim_sync.sv]
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes inputs are asynchronous levels; output is registered.
 */
`timescale 1ns/100ps

module pim_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // Levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule : pim_sync

// [src/pim_core.sv]
/*
 * Prioritised interrupt mask logic of a 16-bit processor: samples the
 * request line and level code, compares against the status word mask,
 * fetches the vector pair, saves the old context and loads the new one.
 * Assumes the instruction sequencer pulses i_instr_boundary between
 * instructions and that memory answers each request with i_mem_ack.
 */
`timescale 1ns/100ps
`include "pim_consts.svh"

module pim_core (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    // Interrupt pins
    input  wire logic                  i_irq_line,
    input  wire pim_pkg::pim_level_t   i_level_code,
    input  wire logic                  i_proc_reset_req,
    input  wire logic                  i_load_req,
    // Sequencer
    input  wire logic                  i_instr_boundary,
    input  wire logic                  i_set_mask_immediate_op,
    input  wire pim_pkg::pim_level_t   i_mask_imm,
    input  wire logic                  i_return_op,
    input  wire pim_pkg::pim_status_t  i_return_status,
    input  wire logic [15:0]           i_cur_wp,
    input  wire logic [15:0]           i_cur_pc,
    // Memory
    output pim_pkg::pim_mem_req_t      o_mem,
    input  wire logic                  i_mem_ack,
    input  wire logic [15:0]           i_mem_rdata,
    // Context and status
    output pim_pkg::pim_status_t       o_status,
    output logic [15:0]                o_new_wp,
    output logic [15:0]                o_new_pc,
    output logic                       o_ctx_load,
    output logic                       o_accepted,
    output pim_pkg::pim_level_t        o_accept_level,
    output logic                       o_busy
);
    import pim_pkg::*;

    pim_state_t  state;
    pim_level_t  level_sync;
    logic        irq_sync;
    logic        rst_req_sync;
    logic        load_req_sync;
    logic        rst_req_prev;
    logic        load_req_prev;
    logic        force_zero;
    logic [15:0] saved_wp;
    logic [15:0] saved_pc;
    pim_status_t saved_status;
    logic        accept;
    pim_level_t  accept_lvl;
    pim_level_t  next_mask;
    logic [15:0] vec_base;

    // Request, code and level-zero pins resynchronised
    pim_sync #(
        .WIDTH (7)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    ({i_irq_line, i_level_code, i_proc_reset_req, i_load_req}),
        .o_sync     ({irq_sync, level_sync, rst_req_sync, load_req_sync})
    );

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_req_prev  <= 1'b0;
            load_req_prev <= 1'b0;
        end else begin
            rst_req_prev  <= rst_req_sync;
            load_req_prev <= load_req_sync;
        end
    end

    // Reset and load pending as level zero; new event beats clear
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            force_zero <= 1'b0;
        end else if ((rst_req_sync && !rst_req_prev) || (load_req_sync && !load_req_prev)) begin
            force_zero <= 1'b1;
        end else if (accept && accept_lvl == 4'h0) begin
            force_zero <= 1'b0;
        end
    end

    // Accept only at a boundary while idle
    always_comb begin
        accept     = 1'b0;
        accept_lvl = level_sync;
        if (state == PIM_IDLE && i_instr_boundary) begin
            if (force_zero) begin
                accept     = 1'b1;
                accept_lvl = 4'h0;
            end else if (irq_sync) begin
                // Mask is the highest level admitted; lower number wins
                accept = (level_sync <= o_status.mask) || (level_sync == 4'h0);
            end
        end
    end

    // One below the accepted level, level zero stays at zero
    always_comb begin
        next_mask = (accept_lvl == 4'h0) ? 4'h0 : accept_lvl - 4'h1;
    end

    // Status word: mask field on acceptance and set-mask, whole word on return
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_status <= `PIM_STATUS_RST;
        end else if (accept) begin
            o_status.mask <= next_mask;
        end else if (i_return_op) begin
            o_status <= i_return_status;
        end else if (i_set_mask_immediate_op) begin
            o_status.mask <= i_mask_imm;
        end
    end

    // Old context captured at acceptance, before the mask changes
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            saved_wp       <= 16'h0000;
            saved_pc       <= 16'h0000;
            saved_status   <= `PIM_STATUS_RST;
            o_accept_level <= 4'h0;
        end else if (accept) begin
            saved_wp       <= i_cur_wp;
            saved_pc       <= i_cur_pc;
            saved_status   <= o_status;
            o_accept_level <= accept_lvl;
        end
    end

    always_comb begin
        vec_base = {10'h000, o_accept_level, 2'b00};
    end

    // Service sequence
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= PIM_IDLE;
        end else begin
            case (state)
                PIM_IDLE: begin
                    if (accept) begin
                        state <= PIM_VEC_WP;
                    end
                end
                PIM_VEC_WP: begin
                    if (i_mem_ack) begin
                        state <= PIM_VEC_PC;
                    end
                end
                PIM_VEC_PC: begin
                    if (i_mem_ack) begin
                        state <= PIM_SAV_WP;
                    end
                end
                PIM_SAV_WP: begin
                    if (i_mem_ack) begin
                        state <= PIM_SAV_PC;
                    end
                end
                PIM_SAV_PC: begin
                    if (i_mem_ack) begin
                        state <= PIM_SAV_ST;
                    end
                end
                PIM_SAV_ST: begin
                    if (i_mem_ack) begin
                        state <= PIM_FIRST;
                    end
                end
                // Hold off preemption until first instruction ends
                PIM_FIRST: begin
                    if (i_instr_boundary) begin
                        state <= PIM_IDLE;
                    end
                end
                default: begin
                    state <= PIM_IDLE;
                end
            endcase
        end
    end

    // Vector pair words land in the new context
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_new_wp <= 16'h0000;
            o_new_pc <= 16'h0000;
        end else if (i_mem_ack && state == PIM_VEC_WP) begin
            o_new_wp <= i_mem_rdata;
        end else if (i_mem_ack && state == PIM_VEC_PC) begin
            o_new_pc <= i_mem_rdata;
        end
    end

    // Memory request driven for the state entered next
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem <= '0;
        end else if (accept) begin
            // Workspace pointer vector at level times four
            o_mem <= {1'b1, 1'b0, {10'h000, accept_lvl, 2'b00}, 16'h0000};
        end else if (i_mem_ack) begin
            case (state)
                PIM_VEC_WP: begin
                    o_mem <= {1'b1, 1'b0, vec_base + `PIM_VEC_PC_OFS, 16'h0000};
                end
                // Old context into registers 13, 14 and 15
                PIM_VEC_PC: begin
                    o_mem <= {1'b1, 1'b1, o_new_wp + `PIM_WS_R13_OFS, saved_wp};
                end
                PIM_SAV_WP: begin
                    o_mem <= {1'b1, 1'b1, o_new_wp + `PIM_WS_R14_OFS, saved_pc};
                end
                PIM_SAV_PC: begin
                    o_mem <= {1'b1, 1'b1, o_new_wp + `PIM_WS_R15_OFS, 16'(saved_status)};
                end
                default: begin
                    o_mem <= '0;
                end
            endcase
        end
    end

    // Strobes and busy flag
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_accepted <= 1'b0;
            o_ctx_load <= 1'b0;
            o_busy     <= 1'b0;
        end else begin
            o_accepted <= accept;
            o_ctx_load <= i_mem_ack && state == PIM_SAV_ST;
            o_busy     <= accept || (state != PIM_IDLE &&
                          !(state == PIM_FIRST && i_instr_boundary));
        end
    end

endmodule : pim_core

// [tb/pim_core_checker.sv]
/* Port assertions for pim_core.
   Bound to each pim_core; one clock, async high reset. */
`timescale 1ns/100ps

module pim_core_checker (
    // Inputs
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_instr_boundary,
    input wire logic i_set_mask_immediate_op,
    input wire pim_pkg::pim_level_t i_mask_imm,
    input wire logic i_return_op,
    input wire pim_pkg::pim_status_t i_return_status,
    // Outputs
    input wire pim_pkg::pim_mem_req_t o_mem,
    input wire pim_pkg::pim_status_t o_status,
    input wire logic o_ctx_load,
    input wire logic o_accepted,
    input wire pim_pkg::pim_level_t o_accept_level,
    input wire logic o_busy
);
    import pim_pkg::*;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    a_mask_drop: assert property (o_accepted |-> o_status.mask ==
        (o_accept_level == 4'h0 ? 4'h0 : o_accept_level - 4'h1)) else $error("mask not lowered");
    a_mask_cap: assert property (o_accepted |-> o_accept_level == 4'h0 ||
        o_accept_level <= $past(o_status.mask)) else $error("masked level taken");
    a_vector_read: assert property (o_accepted |-> o_mem.req && !o_mem.we &&
        o_mem.addr == {10'h0, o_accept_level, 2'b00}) else $error("bad vector read");
    a_at_boundary: assert property (o_accepted |-> $past(i_instr_boundary) &&
        !$past(o_busy)) else $error("accept off boundary");
    a_set_mask: assert property (i_set_mask_immediate_op && !i_return_op |=>
        o_accepted || o_status.mask == $past(i_mask_imm)) else $error("mask not set");
    a_ret_restore: assert property (i_return_op |=> o_accepted ||
        o_status == $past(i_return_status)) else $error("status not restored");
    a_first_instr: assert property ($fell(o_busy) |->
        $past(i_instr_boundary)) else $error("service ended early");
    a_ctx_bound: assert property ($rose(o_busy) |-> ##[5:80] o_ctx_load)
        else $error("context save late");
endmodule : pim_core_checker

bind pim_core pim_core_checker u_chk (.i_core_clk, .i_rst, .i_instr_boundary,
    .i_set_mask_immediate_op, .i_mask_imm, .i_return_op, .i_return_status,
    .o_mem, .o_status, .o_ctx_load, .o_accepted, .o_accept_level, .o_busy);

// [tb/pim_mem_model.sv]
/* Memory partner: acks each word access, fast or slow.
   Assumes requests hold until acked. */
`timescale 1ns/100ps

module pim_mem_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire pim_pkg::pim_mem_req_t i_mem,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    import pim_pkg::*;
    logic [1:0] wait_cnt;
    logic [15:0] wr_addr[$], wr_data[$];

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ack <= 1'b0;
            wait_cnt <= 2'h0;
            o_rdata <= 16'h0;
        end else begin
            // Data line toggles every cycle except when answering a read
            o_rdata <= ~o_rdata;
            o_ack <= 1'b0;
            wait_cnt <= i_mem.req ? wait_cnt + 2'h1 : 2'h0;
            if (i_mem.req && !o_ack && (!i_slow || wait_cnt == 2'h3)) begin
                o_ack <= 1'b1;
                if (i_mem.we) begin
                    wr_addr.push_back(i_mem.addr);
                    wr_data.push_back(i_mem.wdata);
                end else begin
                    o_rdata <= 16'h8000 + {i_mem.addr[11:0], 4'h0};
                end
            end
        end
    end
endmodule : pim_mem_model

// [tb/pim_core_tb_top.sv]
/* Self-checking bench for pim_core.
   Assumes pim_mem_model on memory and a boundary every 4 cycles. */
`timescale 1ns/100ps

module pim_core_tb_top;
    import pim_pkg::*;
    logic i_core_clk = 1'b0, i_rst = 1'b1, i_irq_line = 1'b0, i_load_req = 1'b0;
    logic i_proc_reset_req = 1'b0, i_instr_boundary = 1'b0, i_slow = 1'b0;
    logic i_set_mask_immediate_op = 1'b0, i_return_op = 1'b0, mem_ack;
    pim_level_t i_level_code = 4'h0, i_mask_imm = 4'h0, o_accept_level;
    pim_status_t i_return_status = 16'h0, o_status;
    pim_mem_req_t o_mem;
    logic [15:0] o_new_wp, o_new_pc, mem_rdata;
    logic [15:0] cur_wp = 16'h1234, cur_pc = 16'h5678;
    logic o_ctx_load, o_accepted, o_busy;
    int cyc = 0, bad_count = 0, checks_done = 0;

    pim_core uut (.i_core_clk, .i_rst, .i_irq_line, .i_level_code, .i_proc_reset_req,
        .i_load_req, .i_instr_boundary, .i_set_mask_immediate_op, .i_mask_imm, .i_return_op,
        .i_return_status, .i_cur_wp(cur_wp), .i_cur_pc(cur_pc), .o_mem,
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_status, .o_new_wp, .o_new_pc,
        .o_ctx_load, .o_accepted, .o_accept_level, .o_busy);
    pim_mem_model mem (.i_core_clk, .i_rst, .i_slow, .i_mem(o_mem), .o_ack(mem_ack),
        .o_rdata(mem_rdata));

    always #4 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        i_instr_boundary <= !i_rst && cyc % 4 == 0;
        if (cyc == 3000) begin
            bad_count++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic mop(input logic isret, input logic [15:0] v);
        @(posedge i_core_clk);
        i_return_op <= isret;
        i_set_mask_immediate_op <= !isret;
        i_mask_imm <= v[15:12];
        i_return_status <= v;
        @(posedge i_core_clk);
        i_return_op <= 1'b0;
        i_set_mask_immediate_op <= 1'b0;
        #1;
        chk({o_status[15:12], isret ? o_status[11:0] : v[11:0]}, v);
    endtask : mop

    task automatic quiet(input pim_level_t lv);
        logic seen;
        seen = 1'b0;
        @(posedge i_core_clk);
        i_level_code <= lv;
        i_irq_line <= 1'b1;
        repeat (40) @(posedge i_core_clk) if (o_accepted === 1'b1) seen = 1'b1;
        chk({15'h0, seen}, 16'h0);
    endtask : quiet

    task automatic serve(input pim_level_t lv, input logic [15:0] st);
        logic [15:0] a;
        logic [15:0] wp;
        logic [15:0] old_ctx [3];
        a = {10'h0, lv, 2'b00};
        wp = 16'h8000 + {a[11:0], 4'h0};
        old_ctx[0] = cur_wp;
        old_ctx[1] = cur_pc;
        old_ctx[2] = st;
        mem.wr_addr.delete();
        mem.wr_data.delete();
        @(posedge i_core_clk iff o_accepted === 1'b1);
        i_irq_line <= 1'b0;
        i_load_req <= 1'b0;
        i_proc_reset_req <= 1'b0;
        // Context moves on after acceptance; saved words must not follow it
        cur_wp <= cur_wp + 16'h0100;
        cur_pc <= cur_pc + 16'h0100;
        #1;
        chk({12'h0, o_accept_level}, {12'h0, lv});
        chk(o_status, {lv == 4'h0 ? 4'h0 : lv - 4'h1, st[11:0]});
        @(posedge i_core_clk iff o_ctx_load === 1'b1);
        #1;
        chk(o_new_wp, wp);
        chk(o_new_pc, 16'h8020 + {a[11:0], 4'h0});
        for (int i = 0; i < 3; i++) begin
            chk(mem.wr_addr[i], wp + 16'h001a + 16'(2 * i));
            chk(mem.wr_data[i], old_ctx[i]);
        end
        @(posedge i_core_clk iff o_busy === 1'b0);
    endtask : serve

    task automatic t_refuse;
        mop(1'b0, 16'h8000);
        quiet(4'h9);
        i_level_code <= 4'h8;
        serve(4'h8, 16'h8000);
        mop(1'b1, 16'h8000);
        $display("mask test done");
    endtask : t_refuse

    task automatic t_zero;
        mop(1'b0, 16'h0000);
        quiet(4'h1);
        i_level_code <= 4'h0;
        serve(4'h0, 16'h0000);
        i_slow <= 1'b1;
        i_load_req <= 1'b1;
        serve(4'h0, 16'h0000);
        i_proc_reset_req <= 1'b1;
        serve(4'h0, 16'h0000);
        $display("level zero test done");
    endtask : t_zero

    initial begin
        repeat (10) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        t_refuse;
        t_zero;
        report_and_stop;
    end
endmodule : pim_core_tb_top
